// >>> charge_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module charge_sequencer #(
  parameter int TICK_CYCLES = charge_seq_pkg::TICK_CYCLES_DEF,
  parameter int QUAL_CYCLES = charge_seq_pkg::QUAL_CYCLES_DEF,
  parameter int BAD_MS      = charge_seq_pkg::BAD_MS_DEF,
  parameter int SAFE_MS     = charge_seq_pkg::SAFE_MS_DEF
) (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire charge_seq_pkg::cmp_t  cmp_i,
  input  wire logic                  charger_en_i,
  output charge_seq_pkg::cur_t       current_cmd_o,
  output charge_seq_pkg::state_t     phase_o,
  output logic                       charge_status_output_o,
  output logic                       charge_status_output_oe_o
);
  import charge_seq_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int QW = $clog2(QUAL_CYCLES + 2);

  if (TICK_CYCLES < 2 || QUAL_CYCLES < 8 || BAD_MS < 1 || SAFE_MS < 1 ||
      BAD_MS >= (1 << MS_W) || SAFE_MS >= (1 << MS_W)) begin : g_bad_param
    $error("charge_sequencer: timer parameters out of range.");
  end

  function automatic cur_t cmd_of(input state_t s);
    case (s)
      ST_TRICKLE: cmd_of = CUR_TENTH;
      ST_CC,
      ST_FLOAT:   cmd_of = CUR_FULL;
      default:    cmd_of = CUR_ZERO;
    endcase
  endfunction

  function automatic logic charging(input state_t s);
    charging = (s == ST_TRICKLE) || (s == ST_CC) || (s == ST_FLOAT);
  endfunction

  // ********************************************************
  // Reset release and input synchronisers
  // ********************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rstn;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rstn = rst_sync_ff;

  cmp_t cmp_meta_ff;
  cmp_t cmp_ff;

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      cmp_meta_ff <= '0;
      cmp_ff      <= '0;
    end else begin
      cmp_meta_ff <= cmp_i;
      cmp_ff      <= cmp_meta_ff;
    end
  end

  // ********************************************************
  // Restart detection
  // ********************************************************
  logic en_d_ff;
  logic supply_d_ff;
  logic restart;
  logic run;
  logic steady;

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      en_d_ff     <= 1'b0;
      supply_d_ff <= 1'b0;
    end else begin
      en_d_ff     <= charger_en_i;
      supply_d_ff <= cmp_ff.supply_ok;
    end
  end

  assign restart = (charger_en_i && !en_d_ff) || (cmp_ff.supply_ok && !supply_d_ff);
  assign run     = charger_en_i && cmp_ff.supply_ok;
  assign steady  = run && !restart;

  // ********************************************************
  // Millisecond prescaler
  // ********************************************************
  logic [TW-1:0] tick_cnt_ff;
  logic          ms_tick;

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
    end else if (ms_tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TW'(1);
    end
  end

  assign ms_tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));

  // ********************************************************
  // Recharge qualification
  // ********************************************************
  logic [QW-1:0] qual_cnt_ff;
  logic          qual;

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      qual_cnt_ff <= '0;
    end else if (!cmp_ff.below_recharge) begin
      qual_cnt_ff <= '0;
    end else if (qual_cnt_ff != QW'(QUAL_CYCLES + 1)) begin
      qual_cnt_ff <= qual_cnt_ff + QW'(1);
    end
  end

  assign qual = cmp_ff.below_recharge && (qual_cnt_ff == QW'(QUAL_CYCLES));

  // ********************************************************
  // Phase sequencer
  // ********************************************************
  state_t          state_ff;
  state_t          nxt_state;
  state_t          start_phase;
  logic [MS_W-1:0] bad_ms_ff;
  logic [MS_W-1:0] safe_ms_ff;
  logic            bad_expired;
  logic            safe_expired;

  assign start_phase  = cmp_ff.below_trickle ? ST_TRICKLE : ST_CC;
  assign bad_expired  = bad_ms_ff >= MS_W'(BAD_MS);
  assign safe_expired = safe_ms_ff >= MS_W'(SAFE_MS);

  always_comb begin
    nxt_state = state_ff;
    if (!run) begin
      nxt_state = ST_IDLE;
    end else if (restart) begin
      nxt_state = start_phase;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = start_phase;
        end
        ST_TRICKLE: begin
          if (!cmp_ff.below_trickle) begin
            nxt_state = ST_CC;
          end else if (bad_expired) begin
            nxt_state = ST_BADBAT;
          end
        end
        ST_CC: begin
          if (cmp_ff.at_float) begin
            nxt_state = ST_FLOAT;
          end
        end
        ST_FLOAT: begin
          if (safe_expired) begin
            nxt_state = ST_DONE;
          end
        end
        ST_DONE: begin
          if (qual) begin
            nxt_state = start_phase;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      bad_ms_ff <= '0;
    end else if (nxt_state != ST_TRICKLE || restart) begin
      bad_ms_ff <= '0;
    end else if (ms_tick) begin
      bad_ms_ff <= bad_ms_ff + MS_W'(1);
    end
  end

  // safety timer with clear and freeze.
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      safe_ms_ff <= '0;
    end else if (nxt_state != ST_FLOAT || restart || qual) begin
      safe_ms_ff <= '0;
    end else if (state_ff == ST_FLOAT && ms_tick && !cmp_ff.temp_fault) begin
      safe_ms_ff <= safe_ms_ff + MS_W'(1);
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  logic blink_low;
  cur_t cur_ff;
  logic oe_ff;

  status_blinker u_status_blinker (
    .clk_i     (clk_i),
    .rstn_i    (rstn),
    .ms_tick_i (ms_tick),
    .enable_i  (state_ff == ST_BADBAT),
    .low_o     (blink_low)
  );

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= CUR_ZERO;
      oe_ff  <= 1'b0;
    end else begin
      cur_ff <= cmd_of(nxt_state);
      oe_ff  <= charging(nxt_state) || (nxt_state == ST_BADBAT && blink_low);
    end
  end

  assign current_cmd_o = cur_ff;
  assign phase_o       = state_ff;
  assign charge_status_output_o        = 1'b0;
  assign charge_status_output_oe_o     = oe_ff;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn);

  sequence s_supply_cycle;
    !cmp_ff.supply_ok ##1 cmp_ff.supply_ok;
  endsequence

  sequence s_en_cycle;
    !charger_en_i ##1 charger_en_i;
  endsequence

  a_trickle_start : assert property (
    run && restart && cmp_ff.below_trickle |=> state_ff == ST_TRICKLE && current_cmd_o == CUR_TENTH)
    else $error("Trickle not entered at a low-battery start.");

  a_bad_battery : assert property (
    state_ff == ST_TRICKLE && steady && cmp_ff.below_trickle && bad_expired
    |=> state_ff == ST_BADBAT && current_cmd_o == CUR_ZERO)
    else $error("Bad battery not declared at timeout.");

  a_cc_entry : assert property (
    state_ff == ST_TRICKLE && steady && !cmp_ff.below_trickle |=> state_ff == ST_CC && current_cmd_o == CUR_FULL)
    else $error("Full current not commanded above trickle threshold.");

  a_safety_start : assert property (
    state_ff == ST_CC && steady && cmp_ff.at_float |=> state_ff == ST_FLOAT && safe_ms_ff == '0)
    else $error("Safety timer not started at float.");

  a_safety_expire : assert property (
    state_ff == ST_FLOAT && steady && safe_expired |=> state_ff == ST_DONE && current_cmd_o == CUR_ZERO)
    else $error("Charge not terminated at safety expiry.");

  a_auto_recharge : assert property (
    state_ff == ST_DONE && steady && qual |=> state_ff inside {ST_TRICKLE, ST_CC})
    else $error("Recharge did not start a new cycle.");

  a_timer_clear : assert property (
    state_ff == ST_FLOAT && steady && qual && !safe_expired |=> state_ff == ST_FLOAT && safe_ms_ff == '0)
    else $error("Safety timer not cleared by recharge dip.");

  a_qual_filter : assert property (
    $rose(cmp_ff.below_recharge) |-> !qual [*8])
    else $error("Recharge dip qualified too early.");

  a_supply_restart : assert property (
    s_supply_cycle ##0 charger_en_i |=> state_ff inside {ST_TRICKLE, ST_CC} && safe_ms_ff == '0)
    else $error("Supply cycling did not restart charge.");

  a_enable_restart : assert property (
    s_en_cycle ##0 cmp_ff.supply_ok |=> state_ff inside {ST_TRICKLE, ST_CC} && safe_ms_ff == '0)
    else $error("Enable cycling did not restart charge.");

  a_timer_freeze : assert property (
    state_ff == ST_FLOAT && steady && cmp_ff.temp_fault && !qual && !safe_expired |=> $stable(safe_ms_ff))
    else $error("Safety timer ran during temperature fault.");

  a_status_drive : assert property (
    charging(state_ff) |-> charge_status_output_oe_o ##1 (charging(state_ff) || !charge_status_output_oe_o || state_ff == ST_BADBAT))
    else $error("Status not held low while charging.");

  a_idle_hold : assert property (
    !run |=> state_ff == ST_IDLE && current_cmd_o == CUR_ZERO && bad_ms_ff == '0 && safe_ms_ff == '0)
    else $error("Sequencer not idle without enable.");

  a_prescale_gap : assert property (
    ms_tick |=> !ms_tick ##0 tick_cnt_ff == '0)
    else $error("Millisecond ticks too close.");

endmodule

`default_nettype wire

// >>> charge_seq_pkg.sv
// Function
// - Start below trickle: trickle, tenth current.
// - Trickle over half hour: bad battery.
// - Above trickle threshold: full constant current.
// - Float voltage reached starts four-hour timer.
// - Timer expiry terminates with zero current.
// - Terminated: recharge threshold starts new cycle.
// - Qualified recharge dip clears running timer.
// - Recharge dip counts only beyond 1ms.
// - Supply lockout cycling restarts cycle, timer.
// - Host enable off-on restarts cycle, timer.
// - Float with temperature fault freezes timer.
// - Status low while charging, released when done.
// - Bad battery: 35kHz, 12/88% at 4Hz.
`default_nettype none

package charge_seq_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_TIME_NS      = 1000000;
  localparam int TICK_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int QUAL_TIME_NS    = 1000000;
  localparam int QUAL_CYCLES_DEF = QUAL_TIME_NS / CLK_PERIOD_NS;
  localparam int MS_PER_MIN      = 60000;
  localparam int BAD_TIME_MIN    = 30;
  localparam int SAFE_TIME_MIN   = 240;
  localparam int BAD_MS_DEF      = BAD_TIME_MIN * MS_PER_MIN;
  localparam int SAFE_MS_DEF     = SAFE_TIME_MIN * MS_PER_MIN;
  localparam int MS_W            = 24;
  localparam int PULSE_FREQ_HZ   = 35000;
  localparam int PULSE_CYCLES    = 1000000000 / (CLK_PERIOD_NS * PULSE_FREQ_HZ);
  localparam int DUTY_LO_PCT     = 12;
  localparam int DUTY_HI_PCT     = 88;
  localparam int PULSE_W         = 12;
  localparam logic [PULSE_W-1:0] LOW_LO_CYC = PULSE_W'(PULSE_CYCLES * DUTY_LO_PCT / 100);
  localparam logic [PULSE_W-1:0] LOW_HI_CYC = PULSE_W'(PULSE_CYCLES * DUTY_HI_PCT / 100);
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_CYCLES - 1);
  localparam int BLINK_FREQ_HZ   = 4;
  localparam int BLINK_W         = 8;
  localparam logic [BLINK_W-1:0] BLINK_HALF_LAST = BLINK_W'(1000 / (2 * BLINK_FREQ_HZ) - 1);

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {CUR_ZERO, CUR_TENTH, CUR_FULL} cur_t;

  typedef enum logic [2:0] {ST_IDLE, ST_TRICKLE, ST_CC, ST_FLOAT, ST_DONE, ST_BADBAT} state_t;

  typedef struct packed {
    logic below_trickle;
    logic at_float;
    logic below_recharge;
    logic supply_ok;
    logic temp_fault;
  } cmp_t;

endpackage

`default_nettype wire

// >>> status_blinker.sv
`timescale 1ns/10ps
`default_nettype none

module status_blinker (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ms_tick_i,
  input  wire logic enable_i,
  output logic      low_o
);
  import charge_seq_pkg::*;

  logic [PULSE_W-1:0] cyc_ff;
  logic [BLINK_W-1:0] half_ff;
  logic               phase_ff;

  // ********************************************************
  // Carrier period
  // ********************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_ff <= '0;
    end else if (!enable_i || cyc_ff == PULSE_LAST) begin
      cyc_ff <= '0;
    end else begin
      cyc_ff <= cyc_ff + PULSE_W'(1);
    end
  end

  // ********************************************************
  // Blink phase
  // ********************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_ff  <= '0;
      phase_ff <= 1'b0;
    end else if (!enable_i) begin
      half_ff  <= '0;
      phase_ff <= 1'b0;
    end else if (ms_tick_i) begin
      if (half_ff == BLINK_HALF_LAST) begin
        half_ff  <= '0;
        phase_ff <= ~phase_ff;
      end else begin
        half_ff <= half_ff + BLINK_W'(1);
      end
    end
  end

  assign low_o = enable_i && (cyc_ff < (phase_ff ? LOW_HI_CYC : LOW_LO_CYC));

  a_blink_duty_lo : assert property (@(posedge clk_i) disable iff (!rstn_i)
    enable_i && !phase_ff && cyc_ff == LOW_LO_CYC && !(ms_tick_i && half_ff == BLINK_HALF_LAST)
    |-> !low_o ##1 !low_o)
    else $error("Low duty pulse too long.");

  a_blink_duty_hi : assert property (@(posedge clk_i) disable iff (!rstn_i)
    enable_i && phase_ff && cyc_ff == LOW_LO_CYC |-> low_o)
    else $error("High duty pulse too short.");

endmodule

`default_nettype wire

// >>> battery_model.sv
`timescale 1ns/10ps
`default_nettype none

module battery_model (
  input  wire logic [12:0]     bat_mv_i,
  input  wire logic            supply_i,
  input  wire logic            hot_i,
  output charge_seq_pkg::cmp_t cmp_o
);
  import charge_seq_pkg::*;

  // ********************************************************
  // Comparators
  // ********************************************************
  // The recharge threshold sits 100 mV under the float level.
  // trickle threshold.
  assign cmp_o.below_trickle  = (bat_mv_i < 13'hB22);
  assign cmp_o.at_float       = (bat_mv_i >= 13'h1068);
  assign cmp_o.below_recharge = (bat_mv_i < 13'h1004);
  assign cmp_o.supply_ok      = supply_i;
  assign cmp_o.temp_fault     = hot_i;
endmodule

`default_nettype wire

// >>> battery_charge_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end

module battery_charge_sequencer_test;
  import charge_seq_pkg::*;

  // ********************************************************
  // Setup
  // ********************************************************
  // Short counts keep the run small; the blink phase scales with the tick, the 35kHz carrier period does not.
  localparam int TICK = 10;
  localparam int QUAL = 16;
  localparam int BAD  = 20;
  localparam int SAFE = 30;

  logic        clk_i;
  logic        rstn_i;
  logic        en;
  logic        supply;
  logic        hot;
  logic [12:0] mv;
  cmp_t        cmp;
  cur_t        cur;
  state_t      phase;
  logic        charge_status_output;
  logic        charge_status_output_oe;
  logic        pin;
  int          fail_count;
  int          total_checks;

  // Open-drain status pin with a pull-up.
  assign pin = charge_status_output_oe ? charge_status_output : 1'b1;

  battery_model u_battery_model (
    .bat_mv_i (mv),
    .supply_i (supply),
    .hot_i    (hot),
    .cmp_o    (cmp)
  );

  charge_sequencer #(
    .TICK_CYCLES (TICK),
    .QUAL_CYCLES (QUAL),
    .BAD_MS      (BAD),
    .SAFE_MS     (SAFE)
  ) u_charge_sequencer (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .cmp_i         (cmp),
    .charger_en_i  (en),
    .current_cmd_o (cur),
    .phase_o       (phase),
    .charge_status_output_o        (charge_status_output),
    .charge_status_output_oe_o     (charge_status_output_oe)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_phase(input state_t s, input int lim, output int n);
    n = 0;
    while (phase !== s && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (phase !== s) begin
      fail_count++;
      $display("CHECK FAILED t=%0t phase wait ran out", $time);
      give_verdict();
    end
  endtask

  task automatic set_mv(input logic [12:0] v);
    @(posedge clk_i);
    mv <= v;
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_trickle();
    int n;
    `CHK(phase, ST_IDLE, "idle after reset")
    `CHK(cur, CUR_ZERO, "zero current idle")
    @(posedge clk_i);
    en <= 1'b1;
    wait_phase(ST_TRICKLE, 10, n);
    `CHK(cur, CUR_TENTH, "tenth current")
    `CHK(pin, 1'b0, "status low charging")
    set_mv(13'hDAC);
    wait_phase(ST_CC, 10, n);
    `CHK(cur, CUR_FULL, "full current")
    $display("test trickle done");
  endtask

  task automatic t_bad();
    int n;
    int hi;
    @(posedge clk_i);
    en <= 1'b0;
    mv <= 13'h9C4;
    idle(3);
    `CHK(phase, ST_IDLE, "disabled idle")
    `CHK(pin, 1'b1, "status released idle")
    @(posedge clk_i);
    en <= 1'b1;
    wait_phase(ST_TRICKLE, 10, n);
    wait_phase(ST_BADBAT, BAD * TICK + 40, n);
    `CHK(n >= (BAD - 1) * TICK, 1'b1, "bad battery too early")
    `CHK(cur, CUR_ZERO, "bad battery zero current")
    hi = 0;
    repeat (3000) begin
      @(posedge clk_i);
      #1;
      hi += int'(pin === 1'b0);
    end
    `CHK(hi > 0 && hi < 3000, 1'b1, "status pulsing")
    $display("test bad battery done");
  endtask

  task automatic t_float();
    int n;
    @(posedge clk_i);
    mv <= 13'hDAC;
    supply <= 1'b0;
    idle(4);
    `CHK(phase, ST_IDLE, "lockout idle")
    @(posedge clk_i);
    supply <= 1'b1;
    wait_phase(ST_CC, 10, n);
    set_mv(13'h1068);
    wait_phase(ST_FLOAT, 10, n);
    @(posedge clk_i);
    hot <= 1'b1;
    idle(SAFE * TICK + 50);
    `CHK(phase, ST_FLOAT, "timer frozen")
    @(posedge clk_i);
    hot <= 1'b0;
    wait_phase(ST_DONE, SAFE * TICK + 40, n);
    `CHK(cur, CUR_ZERO, "terminated zero current")
    `CHK(pin, 1'b1, "status released done")
    $display("test float done");
  endtask

  task automatic t_recharge();
    int n;
    set_mv(13'hFD2);
    idle(QUAL - 1);
    set_mv(13'h1068);
    idle(20);
    `CHK(phase, ST_DONE, "short dip ignored")
    set_mv(13'hFD2);
    wait_phase(ST_CC, QUAL + 20, n);
    `CHK(cur, CUR_FULL, "recharge started")
    set_mv(13'h1068);
    wait_phase(ST_FLOAT, 10, n);
    idle(20 * TICK);
    set_mv(13'hFD2);
    idle(QUAL + 14);
    set_mv(13'h1068);
    idle(25 * TICK);
    `CHK(phase, ST_FLOAT, "timer cleared by dip")
    wait_phase(ST_DONE, 10 * TICK, n);
    $display("test recharge done");
  endtask

  // ********************************************************
  // Main
  // ********************************************************
  initial begin
    fail_count = 0;
    total_checks = 0;
    rstn_i = 1'b0;
    en = 1'b0;
    supply = 1'b1;
    hot = 1'b0;
    mv = 13'h9C4;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    idle(6);
    t_trickle();
    t_bad();
    t_float();
    t_recharge();
    give_verdict();
  end
endmodule

`default_nettype wire
